// *** aof_pkg.sv ***
package aof_pkg;
  localparam int          DATA_W        = 14;
  localparam int          LATENCY       = 6;
  localparam int          LAT_CNT_W     = 3;
  localparam logic [13:0] OB_ZERO       = 14'h2000;
  localparam logic [13:0] OB_POS_FULL   = 14'h3FFF;
  localparam logic [13:0] OB_NEG_FULL   = 14'h0000;
  localparam int          MSB           = 13;
  localparam real         MIN_CLK_MHZ   = 1.0;
  localparam real         SYS_CLK_MHZ   = 25.0;

  typedef struct packed {
    logic        over_pos;
    logic        over_neg;
    logic [13:0] code;
  } aof_sample_t;

  typedef enum logic [1:0] {AOF_SLEEP, AOF_FILL, AOF_RUN} aof_state_t;
endpackage

// *** aof_pipe_stage.sv ***
`timescale 1ns/100ps
`default_nettype none
module aof_pipe_stage
  import aof_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_clr,
  input  wire aof_sample_t i_d,
  output var  aof_sample_t o_q
);
  always_ff @(posedge i_sys_clk) begin
    if (i_clr) begin
      o_q <= '0;
    end else begin
      o_q <= i_d;
    end
  end
endmodule
`default_nettype wire

// *** aof_adc_format.sv ***
// Notes on behaviour
// R1 - select high gives twos complement, low offset binary
// R2 - twos complement equals offset binary, msb inverted
// R3 - fourteen bit word, zero and full scale codes
// R4 - over-range saturates to selected format full scale
// R5 - output enable low drives, high floats outputs
// R6 - partner must not toggle enable dynamically
// R7 - sleep request stops conversion, reference stays
// R8 - sleep discards pipeline; valid after full latency
// R9 - unused sleep request held low by partner
// R10 - conversion clock kept at least 1MHz
// R11 - clock duty cycle fifty percent at speed
// R12 - each cycle captures sample, advances pipeline
// R13 - latency parameter; valid low after sleep
// R14 - coding change affects next word and every later word
`timescale 1ns/100ps
`default_nettype none
module aof_adc_format
  import aof_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic [13:0] i_sample,
  input  wire logic        i_over_pos,
  input  wire logic        i_over_neg,
  input  wire logic        i_twos_complement_select,
  input  wire logic        i_out_enable_n,
  input  wire logic        i_sleep_request,
  output var  logic [13:0] o_data,
  output var  logic [13:0] o_data_oe,
  output var  logic        o_data_valid,
  output var  logic        o_ref_active
);
  logic        btc_m_ff;
  logic        btc_ff;
  logic        oe_n_m_ff;
  logic        oe_n_ff;
  logic        slp_m_ff;
  logic        slp_ff;
  aof_state_t  state_ff, nxt_state;
  logic [LAT_CNT_W-1:0] cnt_ff, nxt_cnt;
  aof_sample_t stage [0:LATENCY];
  aof_sample_t tail;
  logic [13:0] ob_word;
  logic [13:0] fmt_word;
  logic        run_ok;
  logic        pipe_clr;
  logic        fill_done;
  logic [13:0] nxt_data_oe;

  // pin synchronisers
  always_ff @(posedge i_sys_clk) begin
    btc_m_ff  <= i_twos_complement_select;
    btc_ff    <= btc_m_ff;
    oe_n_m_ff <= i_out_enable_n;
    oe_n_ff   <= oe_n_m_ff;
    slp_m_ff  <= i_sleep_request;
    slp_ff    <= slp_m_ff;
  end

  // pipeline capture, cleared while asleep
  assign stage[0] = '{over_pos: i_over_pos, over_neg: i_over_neg, code: i_sample}; // R12
  assign pipe_clr = slp_ff | ~i_nrst; // R8 R7
  genvar g;
  generate
    for (g = 0; g < LATENCY; g++) begin : g_pipe
      aof_pipe_stage u_stage (
        .i_sys_clk (i_sys_clk),
        .i_clr     (pipe_clr),         // R8 R7
        .i_d       (stage[g]),        // R12
        .o_q       (stage[g+1])
      );
    end
  endgenerate
  assign tail = stage[LATENCY];

  // saturation then coding, coding taken at output time
  assign ob_word  = tail.over_pos ? OB_POS_FULL : (tail.over_neg ? OB_NEG_FULL : tail.code); // R4 R3
  assign fmt_word = btc_ff ? {~ob_word[MSB], ob_word[MSB-1:0]} : ob_word; // R1 R2 R14

  // latency tracking after sleep
  assign fill_done = (cnt_ff == LAT_CNT_W'(LATENCY - 1)); // R13
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      AOF_SLEEP: begin
        nxt_cnt = '0;
        if (!slp_ff) begin
          nxt_state = AOF_FILL;
        end
      end
      AOF_FILL: begin
        if (slp_ff) begin
          nxt_state = AOF_SLEEP;
        end else if (fill_done) begin
          nxt_state = AOF_RUN; // R13 R8
        end else begin
          nxt_cnt = cnt_ff + LAT_CNT_W'(1);
        end
      end
      AOF_RUN: begin
        if (slp_ff) begin
          nxt_state = AOF_SLEEP;
        end
      end
    endcase
  end
  assign run_ok = (nxt_state == AOF_RUN);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_ff <= AOF_SLEEP;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // registered outputs
  assign nxt_data_oe = {DATA_W{~oe_n_ff}}; // R5
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_data       <= OB_ZERO;
      o_data_oe    <= '0;
      o_data_valid <= 1'b0;
      o_ref_active <= 1'b1;
    end else begin
      o_data       <= fmt_word;
      o_data_oe    <= nxt_data_oe;       // R5
      o_data_valid <= run_ok;             // R13
      o_ref_active <= 1'b1;               // R7
    end
  end

  a_valid_after_wake: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R13
    $fell(slp_ff) |-> !o_data_valid [*5]) else $error("valid too early after sleep");
  a_sleep_kills_valid: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R8
    slp_ff |=> !o_data_valid) else $error("valid during sleep");
  a_msb_flip: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R2
    btc_ff |=> o_data == {~$past(ob_word[MSB]), $past(ob_word[MSB-1:0])}) else $error("btc msb wrong");
  a_ob_pass: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R1
    !btc_ff |=> o_data == $past(ob_word)) else $error("offset binary wrong");
  a_sat_pos: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R4
    tail.over_pos |=> o_data == (OB_POS_FULL ^ {$past(btc_ff), {MSB{1'b0}}})) else $error("no positive saturation");
  a_sat_neg: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R4
    (tail.over_neg && !tail.over_pos) |=> o_data == (OB_NEG_FULL ^ {$past(btc_ff), {MSB{1'b0}}}))
    else $error("no negative saturation");
  a_oe_drive: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R5
    oe_n_ff |=> o_data_oe == '0) else $error("drives while disabled");
  a_oe_on: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R5
    !oe_n_ff |=> &o_data_oe) else $error("floats while enabled");
  a_pipe_shift: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || slp_ff) // R12
    !$past(slp_ff) && $past(i_nrst) |-> stage[1] == $past(stage[0])) else $error("pipeline did not advance");
  a_ref_on: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // R7
    slp_ff |=> o_ref_active) else $error("reference dropped");

  // wake steps: sleep or reset let go, then sleep kept off through the fill
  sequence s_sleep_exit;
    $fell(slp_ff);
  endsequence
  sequence s_reset_exit;
    $rose(i_nrst) && !slp_ff;
  endsequence
  sequence s_fill_quiet;
    !slp_ff [*6];
  endsequence

  property p_valid_on_time;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    s_sleep_exit ##1 s_fill_quiet |=> o_data_valid;
  endproperty
  a_valid_on_time: assert property (p_valid_on_time) else $error("valid late after sleep"); // R13

  property p_valid_not_early;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    s_sleep_exit ##1 s_fill_quiet |-> !o_data_valid;
  endproperty
  a_valid_not_early: assert property (p_valid_not_early) else $error("valid early after sleep"); // R8

  property p_valid_after_reset;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    s_reset_exit ##1 s_fill_quiet |=> o_data_valid;
  endproperty
  a_valid_after_reset: assert property (p_valid_after_reset) else $error("valid late after reset"); // R13

  property p_valid_holds;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_data_valid && !slp_ff |=> o_data_valid;
  endproperty
  a_valid_holds: assert property (p_valid_holds) else $error("valid dropped while running"); // R12

  property p_pipe_cleared;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    slp_ff |=> (stage[1] == '0) && (tail == '0);
  endproperty
  a_pipe_cleared: assert property (p_pipe_cleared) else $error("pipeline kept data in sleep"); // R8

  property p_low_bits_kept;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    1'b1 |=> o_data[MSB-1:0] == $past(ob_word[MSB-1:0]);
  endproperty
  a_low_bits_kept: assert property (p_low_bits_kept) else $error("low bits altered"); // R2

  property p_cnt_bounded;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    cnt_ff <= LAT_CNT_W'(LATENCY - 1);
  endproperty
  a_cnt_bounded: assert property (p_cnt_bounded) else $error("fill counter overran"); // R13

  property p_sleep_halts;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    slp_ff |=> state_ff == AOF_SLEEP;
  endproperty
  a_sleep_halts: assert property (p_sleep_halts) else $error("conversion not halted"); // R7

  property p_coding_next;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    $changed(btc_ff) |=> o_data[MSB] == ($past(btc_ff) ^ $past(ob_word[MSB]));
  endproperty
  a_coding_next: assert property (p_coding_next) else $error("coding change late"); // R14
endmodule
`default_nettype wire

// *** aof_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
module aof_sink
  import aof_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic [13:0] i_data,
  input  wire logic [13:0] i_data_oe,
  input  wire logic        i_data_valid,
  output var  logic [13:0] o_word
);
  logic [13:0] last_ff = 14'h0000;
  logic [13:0] bus;
  // floating bits show the inverse of their last level
  assign bus = (i_data & i_data_oe) | (~last_ff & ~i_data_oe);
  always_ff @(posedge i_sys_clk) begin
    last_ff <= bus;
    if (i_data_valid)
      o_word <= bus;
  end
endmodule
`default_nettype wire

// *** tb_adc_output_format_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_adc_output_format_control;
  import aof_pkg::*;
  logic i_sys_clk = 1'b0, i_nrst = 1'b0, pos = 1'b0, neg = 1'b0, sel = 1'b0, en_n = 1'b0, slp = 1'b0;
  logic [13:0] smp = 14'h2000, o_data, o_data_oe, word;
  logic o_data_valid, o_ref_active;
  int miscompares = 0, checks = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  aof_adc_format u_aof_adc_format (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sample(smp),
    .i_over_pos(pos), .i_over_neg(neg), .i_twos_complement_select(sel), .i_out_enable_n(en_n),
    .i_sleep_request(slp), .o_data(o_data), .o_data_oe(o_data_oe), .o_data_valid(o_data_valid),
    .o_ref_active(o_ref_active));
  aof_sink u_aof_sink (.i_sys_clk(i_sys_clk), .i_data(o_data), .i_data_oe(o_data_oe),
    .i_data_valid(o_data_valid), .o_word(word));
  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $realtime, got, exp);
    end
  endtask
  task automatic wait_valid(input logic lvl);
    int k;
    k = 0;
    while (o_data_valid !== lvl && k < 12) begin
      @(negedge i_sys_clk);
      k++;
    end
    chk({13'h0000, o_data_valid}, {13'h0000, lvl});
    if (o_data_valid !== lvl)
      finish_test();
  endtask
  task automatic hold_low();
    repeat (LATENCY) begin
      @(negedge i_sys_clk);
      chk({13'h0000, o_data_valid}, 14'h0000);
    end
    wait_valid(1'b1);
  endtask
  task automatic put(input logic [13:0] s, input logic p, input logic n, input logic c);
    {smp, pos, neg, sel} = {s, p, n, c};
    repeat (12) @(negedge i_sys_clk);
  endtask
  task automatic t_coding();
    logic [13:0] tbl [4] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h3000};
    for (int c = 0; c < 2; c++)
      foreach (tbl[i]) begin
        put(tbl[i], 1'b0, 1'b0, c[0]);
        chk(word, tbl[i] ^ {c[0], 13'h0000});
      end
  endtask
  task automatic t_over();
    for (int c = 0; c < 2; c++) begin
      put(14'h1234, 1'b1, 1'b0, c[0]);
      chk(word, c[0] ? 14'h1FFF : OB_POS_FULL);
      put(14'h1234, 1'b0, 1'b1, c[0]);
      chk(word, c[0] ? 14'h2000 : OB_NEG_FULL);
    end
  endtask
  task automatic t_ramp();
    logic [13:0] prev;
    put(14'h0100, 1'b0, 1'b0, 1'b0);
    for (int i = 1; i < 24; i++) begin
      prev = word;
      smp = 14'h0100 + 14'(i);
      @(negedge i_sys_clk);
      if (i > 10)
        chk(word, prev + 14'h0001);
    end
  endtask
  task automatic t_oe();
    en_n = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    chk(o_data_oe, 14'h0000);
    en_n = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk(o_data_oe, 14'h3FFF);
  endtask
  task automatic t_sleep();
    slp = 1'b1;
    wait_valid(1'b0);
    chk({13'h0000, o_ref_active}, 14'h0001);
    slp = 1'b0;
    hold_low();
  endtask
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    hold_low();
    t_coding();
    t_over();
    t_ramp();
    t_oe();
    t_sleep();
    finish_test();
  end
endmodule
`default_nettype wire
